// >>> src/tfsa_top.sv
`timescale 1ns/1ps
// How it works
// - standby equal match pick: clear, answer, arbitrate
// - standby differing pick: clear, answer, arbitrate
// - pick in arbitration always clears and answers
// - zero mask: equal pick selects every tag, differing pick none
// - matching drop returns silently to standby
// - failed drop clears, answers, keeps arbitrating
// - other flag command cases stay silent
// - collision bumps counter if nonzero or random
// - answer after collision/next round if zero
// - next round decrements nonzero counter
// - repeat answers only with zero counter
// - return idle: standby, clear transfer, silent
// - frame: preamble, delimiter, code, crc
// - answer: preamble, number, crc
// - fetch with own number sends eight bytes
// - matching fetch marks address as lockable
module tfsa_top #(
   parameter int MEM_AW = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic rx_sof,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_eof,
   input wire logic [7:0] tag_status_byte,
   input wire logic [63:0] unique_tag_number,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic tx_is_preamble,
   output logic [7:0] tx_data,
   output logic tx_last,
   output logic transfer_status_bit,
   output logic arbitration_active,
   output logic [7:0] slot_counter,
   output logic lock_prep_valid,
   output logic [MEM_AW-1:0] lock_prep_addr,
   input wire logic mem_load_en,
   input wire logic [MEM_AW-1:0] mem_load_addr,
   input wire logic [7:0] mem_load_data
);
   // the demodulator and modulator run on ref_clk, so no synchronisers are needed here

   // receive side state
   logic busy_r, busy_nxt; // inside a frame
   logic [3:0] cnt_r, cnt_nxt; // bytes seen after the delimiter
   logic bad_r, bad_nxt; // frame overran the counter
   logic [15:0] hold_r, hold_nxt; // last two bytes, the crc once the frame ends
   logic [7:0] code_r, code_nxt; // command code
   logic [79:0] par_r, par_nxt; // parameter bytes, newest in the low byte
   logic rxcrc_clr, rxcrc_en;
   logic [15:0] rxcrc;
   logic [3:0] len_want; // parameter bytes this code must carry
   logic len_known;
   logic frame_end; // well-formed end of a frame
   logic crc_ok;
   logic exec; // a checked command acts this cycle

   // tag state
   tfsa_pkg::tfsa_state_t state_r, state_nxt;
   logic [7:0] slot_r, slot_nxt;
   logic [15:0] lfsr_r, lfsr_nxt; // random bit source, steps every enabled cycle
   logic lock_v_r, lock_v_nxt;
   logic [MEM_AW-1:0] lock_a_r, lock_a_nxt;
   logic [MEM_AW-1:0] base_r, base_nxt; // start address of a fetched block
   logic resp_uid, resp_mem; // start an answer
   logic status_eq; // masked status compare
   logic id_match;

   // answer side state
   tfsa_pkg::tfsa_tx_t tx_r, tx_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [7:0] data_r, data_nxt;
   logic src_mem_r, src_mem_nxt;
   logic txcrc_clr, txcrc_en;
   logic [15:0] txcrc;
   logic [7:0] mem_rd;
   logic [MEM_AW-1:0] mem_rd_addr;

   // frame intake: the crc trails, so each byte is treated as payload only two bytes later
   always_comb
   begin
      busy_nxt = busy_r;
      cnt_nxt = cnt_r;
      bad_nxt = bad_r;
      hold_nxt = hold_r;
      code_nxt = code_r;
      par_nxt = par_r;
      rxcrc_clr = 1'b0;
      rxcrc_en = 1'b0;
      if (rx_sof)
      begin
         // a fresh delimiter always restarts parsing, a torn frame is dropped
         busy_nxt = 1'b1;
         cnt_nxt = 4'h0;
         bad_nxt = 1'b0;
         rxcrc_clr = 1'b1;
      end
      else if (busy_r && rx_valid)
      begin
         hold_nxt = {hold_r[7:0], rx_byte};
         if (cnt_r != tfsa_pkg::RX_CNT_MAX)
            cnt_nxt = cnt_r + 4'h1;
         else
            bad_nxt = 1'b1;
         if (cnt_r >= tfsa_pkg::RX_CRC_BYTES)
         begin
            // byte two places back is payload: code first, then parameters
            rxcrc_en = 1'b1;
            if (cnt_r == tfsa_pkg::RX_CRC_BYTES)
               code_nxt = hold_r[15:8];
            else
               par_nxt = {par_r[71:0], hold_r[15:8]};
         end
      end
      else if (rx_eof)
         busy_nxt = 1'b0;
   end

   // receive registers
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
         bad_r <= 1'b0;
         hold_r <= 16'h0000;
         code_r <= 8'h00;
         par_r <= 80'h0;
      end
      else if (ce)
      begin
         busy_r <= busy_nxt;
         cnt_r <= cnt_nxt;
         bad_r <= bad_nxt;
         hold_r <= hold_nxt;
         code_r <= code_nxt;
         par_r <= par_nxt;
      end
   end

   tfsa_crc16 u_rx_crc (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .clear(rxcrc_clr),
      .en(rxcrc_en),
      .data(hold_r[15:8]),
      .crc(rxcrc)
   );

   // parameter length each code must carry; unknown codes are ignored
   always_comb
   begin
      len_known = 1'b1;
      len_want = tfsa_pkg::LEN_IDENT_CMD;
      if (code_r == tfsa_pkg::CMD_PICK_MATCH || code_r == tfsa_pkg::CMD_PICK_DIFFERS ||
          code_r == tfsa_pkg::CMD_DROP_MATCH || code_r == tfsa_pkg::CMD_DROP_DIFFERS)
         len_want = tfsa_pkg::LEN_FLAG_CMD;
      else if (code_r == tfsa_pkg::CMD_FETCH_BLOCK)
         len_want = tfsa_pkg::LEN_FETCH_CMD;
      else if (code_r != tfsa_pkg::CMD_COLLISION && code_r != tfsa_pkg::CMD_NEXT_ROUND &&
               code_r != tfsa_pkg::CMD_REPEAT_NUMBER && code_r != tfsa_pkg::CMD_RETURN_ALL_IDLE)
         len_known = 1'b0;
   end

   // a frame acts only if crc, length and code check, and no answer is still going out
   assign crc_ok = (rxcrc == hold_r);
   assign frame_end = rx_eof && !rx_sof && busy_r && !bad_r &&
                      (cnt_r > tfsa_pkg::RX_CRC_BYTES);
   assign exec = ce && frame_end && crc_ok && len_known &&
                 (cnt_r - tfsa_pkg::RX_CRC_BYTES - 4'h1 == len_want) &&
                 (tx_r == tfsa_pkg::TFSA_TX_IDLE);

   // flag commands: par holds address, mask, then the compare byte first among the data
   assign status_eq = ((tag_status_byte ^ par_r[63:56]) & par_r[71:64]) == 8'h00;
   assign id_match = (par_r[71:8] == unique_tag_number);

   // command interpreter
   always_comb
   begin
      state_nxt = state_r;
      slot_nxt = slot_r;
      lfsr_nxt = {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? tfsa_pkg::LFSR_TAPS : 16'h0000);
      lock_v_nxt = 1'b0;
      lock_a_nxt = lock_a_r;
      base_nxt = base_r;
      resp_uid = 1'b0;
      resp_mem = 1'b0;
      if (exec)
      begin
         case (code_r)
            tfsa_pkg::CMD_PICK_MATCH, tfsa_pkg::CMD_PICK_DIFFERS:
            begin
               if (state_r == tfsa_pkg::TFSA_ARBITRATION)
               begin
                  slot_nxt = tfsa_pkg::SLOT_RESET;
                  resp_uid = 1'b1;
               end
               else if (state_r == tfsa_pkg::TFSA_STANDBY &&
                        (status_eq == (code_r == tfsa_pkg::CMD_PICK_MATCH)))
               begin
                  slot_nxt = tfsa_pkg::SLOT_RESET;
                  resp_uid = 1'b1;
                  state_nxt = tfsa_pkg::TFSA_ARBITRATION;
               end
               // transfer state or unmet compare: silent and unchanged
            end
            tfsa_pkg::CMD_DROP_MATCH, tfsa_pkg::CMD_DROP_DIFFERS:
            begin
               if (state_r == tfsa_pkg::TFSA_ARBITRATION)
               begin
                  if (status_eq == (code_r == tfsa_pkg::CMD_DROP_MATCH))
                     state_nxt = tfsa_pkg::TFSA_STANDBY;
                  else
                  begin
                     slot_nxt = tfsa_pkg::SLOT_RESET;
                     resp_uid = 1'b1;
                  end
               end
               // outside arbitration nothing happens
            end
            tfsa_pkg::CMD_COLLISION:
            begin
               // only tags taking part in arbitration back off or answer
               if (state_r == tfsa_pkg::TFSA_ARBITRATION)
               begin
                  if ((slot_r != tfsa_pkg::SLOT_RESET) || lfsr_r[0])
                  begin
                     if (slot_r != tfsa_pkg::SLOT_MAX)
                        slot_nxt = slot_r + 8'h01;
                  end
                  else
                     resp_uid = 1'b1;
               end
            end
            tfsa_pkg::CMD_NEXT_ROUND:
            begin
               if (state_r == tfsa_pkg::TFSA_ARBITRATION)
               begin
                  if (slot_r != tfsa_pkg::SLOT_RESET)
                     slot_nxt = slot_r - 8'h01;
                  resp_uid = (slot_r == tfsa_pkg::SLOT_RESET) ||
                             (slot_r == 8'h01);
               end
            end
            tfsa_pkg::CMD_REPEAT_NUMBER:
            begin
               if (state_r == tfsa_pkg::TFSA_ARBITRATION && slot_r == tfsa_pkg::SLOT_RESET)
                  resp_uid = 1'b1;
            end
            tfsa_pkg::CMD_RETURN_ALL_IDLE:
            begin
               state_nxt = tfsa_pkg::TFSA_STANDBY;
            end
            tfsa_pkg::CMD_FETCH_BLOCK:
            begin
               if (id_match)
               begin
                  state_nxt = tfsa_pkg::TFSA_TRANSFER;
                  resp_mem = 1'b1;
                  base_nxt = par_r[MEM_AW-1:0];
                  lock_v_nxt = 1'b1;
                  lock_a_nxt = par_r[MEM_AW-1:0];
               end
            end
            default:
            begin
               state_nxt = state_r;
            end
         endcase
      end
   end

   // tag registers
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_r <= tfsa_pkg::TFSA_STANDBY;
         slot_r <= tfsa_pkg::SLOT_RESET;
         lfsr_r <= tfsa_pkg::LFSR_SEED;
         lock_v_r <= 1'b0;
         lock_a_r <= '0;
         base_r <= '0;
      end
      else if (ce)
      begin
         state_r <= state_nxt;
         slot_r <= slot_nxt;
         lfsr_r <= lfsr_nxt;
         lock_v_r <= lock_v_nxt;
         lock_a_r <= lock_a_nxt;
         base_r <= base_nxt;
      end
   end

   // answer sequencer: preamble, eight body bytes, crc high then low
   assign mem_rd_addr = base_r + MEM_AW'(idx_r);
   always_comb
   begin
      tx_nxt = tx_r;
      idx_nxt = idx_r;
      data_nxt = data_r;
      src_mem_nxt = src_mem_r;
      txcrc_clr = 1'b0;
      txcrc_en = 1'b0;
      case (tx_r)
         tfsa_pkg::TFSA_TX_IDLE:
         begin
            if (resp_uid || resp_mem)
            begin
               tx_nxt = tfsa_pkg::TFSA_TX_PRE;
               idx_nxt = 3'h0;
               src_mem_nxt = resp_mem;
               txcrc_clr = 1'b1;
            end
         end
         tfsa_pkg::TFSA_TX_PRE:
            if (tx_ready)
               tx_nxt = tfsa_pkg::TFSA_TX_LOAD;
         tfsa_pkg::TFSA_TX_LOAD:
            // memory address is presented now, its data arrive next cycle
            tx_nxt = tfsa_pkg::TFSA_TX_FILL;
         tfsa_pkg::TFSA_TX_FILL:
         begin
            data_nxt = src_mem_r ? mem_rd : unique_tag_number[8*(7-idx_r) +: 8];
            txcrc_en = 1'b1;
            tx_nxt = tfsa_pkg::TFSA_TX_SEND;
         end
         tfsa_pkg::TFSA_TX_SEND:
         begin
            if (tx_ready)
            begin
               if (idx_r == tfsa_pkg::TX_LAST_IDX)
               begin
                  data_nxt = txcrc[15:8];
                  tx_nxt = tfsa_pkg::TFSA_TX_CRCH;
               end
               else
               begin
                  idx_nxt = idx_r + 3'h1;
                  tx_nxt = tfsa_pkg::TFSA_TX_LOAD;
               end
            end
         end
         tfsa_pkg::TFSA_TX_CRCH:
         begin
            if (tx_ready)
            begin
               data_nxt = txcrc[7:0];
               tx_nxt = tfsa_pkg::TFSA_TX_CRCL;
            end
         end
         tfsa_pkg::TFSA_TX_CRCL:
            if (tx_ready)
               tx_nxt = tfsa_pkg::TFSA_TX_IDLE;
         default:
            tx_nxt = tfsa_pkg::TFSA_TX_IDLE;
      endcase
   end

   // answer registers
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         tx_r <= tfsa_pkg::TFSA_TX_IDLE;
         idx_r <= 3'h0;
         data_r <= 8'h00;
         src_mem_r <= 1'b0;
      end
      else if (ce)
      begin
         tx_r <= tx_nxt;
         idx_r <= idx_nxt;
         data_r <= data_nxt;
         src_mem_r <= src_mem_nxt;
      end
   end

   tfsa_crc16 u_tx_crc (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .clear(txcrc_clr),
      .en(txcrc_en),
      .data(data_nxt),
      .crc(txcrc)
   );

   tfsa_mem #(.AW(MEM_AW), .DW(8)) u_mem (
      .ref_clk(ref_clk),
      .ce(ce),
      .wr_en(mem_load_en),
      .wr_addr(mem_load_addr),
      .wr_data(mem_load_data),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_rd)
   );

   // outputs
   assign tx_valid = (tx_r == tfsa_pkg::TFSA_TX_PRE) || (tx_r == tfsa_pkg::TFSA_TX_SEND) ||
                     (tx_r == tfsa_pkg::TFSA_TX_CRCH) || (tx_r == tfsa_pkg::TFSA_TX_CRCL);
   assign tx_is_preamble = (tx_r == tfsa_pkg::TFSA_TX_PRE);
   assign tx_last = (tx_r == tfsa_pkg::TFSA_TX_CRCL);
   assign tx_data = data_r;
   assign transfer_status_bit = (state_r == tfsa_pkg::TFSA_TRANSFER);
   assign arbitration_active = (state_r == tfsa_pkg::TFSA_ARBITRATION);
   assign slot_counter = slot_r;
   assign lock_prep_valid = lock_v_r;
   assign lock_prep_addr = lock_a_r;

   // checks
   a_pick_enters_arb: assert property (@(posedge ref_clk) disable iff (rst)
      exec && code_r == tfsa_pkg::CMD_PICK_MATCH && status_eq &&
      state_r == tfsa_pkg::TFSA_STANDBY |=> arbitration_active && slot_r == 8'h00 && tx_valid)
      else $error("equal pick did not select the tag");
   a_pick_arb_always: assert property (@(posedge ref_clk) disable iff (rst)
      exec && code_r == tfsa_pkg::CMD_PICK_DIFFERS && arbitration_active
      |=> arbitration_active && slot_r == 8'h00 && tx_r == tfsa_pkg::TFSA_TX_PRE)
      else $error("pick in arbitration did not answer");
   a_drop_silent: assert property (@(posedge ref_clk) disable iff (rst)
      exec && code_r == tfsa_pkg::CMD_DROP_MATCH && arbitration_active && status_eq
      |=> state_r == tfsa_pkg::TFSA_STANDBY ##0 !tx_valid [*3])
      else $error("matching drop was not silent");
   a_coll_saturates: assert property (@(posedge ref_clk) disable iff (rst)
      exec && code_r == tfsa_pkg::CMD_COLLISION && arbitration_active && slot_r == 8'hFF
      |=> slot_r == 8'hFF && !tx_valid)
      else $error("collision moved a full counter");
   a_next_decrements: assert property (@(posedge ref_clk) disable iff (rst)
      exec && code_r == tfsa_pkg::CMD_NEXT_ROUND && arbitration_active && slot_r != 8'h00
      |=> slot_r == $past(slot_r) - 8'h01)
      else $error("next round did not decrement");
   a_repeat_quiet: assert property (@(posedge ref_clk) disable iff (rst)
      exec && code_r == tfsa_pkg::CMD_REPEAT_NUMBER && slot_r != 8'h00
      |=> $stable(slot_r) && tx_r == tfsa_pkg::TFSA_TX_IDLE)
      else $error("repeat answered with a nonzero counter");
   a_idle_clears: assert property (@(posedge ref_clk) disable iff (rst)
      exec && code_r == tfsa_pkg::CMD_RETURN_ALL_IDLE
      |=> !transfer_status_bit && !arbitration_active && !tx_valid [*2])
      else $error("return idle left a state set or answered");
   a_fetch_locks: assert property (@(posedge ref_clk) disable iff (rst)
      exec && code_r == tfsa_pkg::CMD_FETCH_BLOCK && id_match
      |=> lock_prep_valid && lock_prep_addr == $past(par_r[MEM_AW-1:0]) && transfer_status_bit)
      else $error("matching fetch did not mark the byte");
   a_bad_crc_inert: assert property (@(posedge ref_clk) disable iff (rst)
      ce && frame_end && !crc_ok |=> $stable(state_r) && $stable(slot_r) && !lock_prep_valid)
      else $error("frame with bad crc changed the tag");
   a_answer_order: assert property (@(posedge ref_clk) disable iff (rst)
      ce && tx_r == tfsa_pkg::TFSA_TX_IDLE && tx_nxt == tfsa_pkg::TFSA_TX_PRE
      |=> tx_valid && tx_is_preamble && !tx_last)
      else $error("answer did not open with the preamble");
endmodule

// >>> src/tfsa_pkg.sv
package tfsa_pkg;
   // command codes of the forward link (one byte after the start delimiter)
   localparam logic [7:0] CMD_PICK_MATCH = 8'h1A;
   localparam logic [7:0] CMD_PICK_DIFFERS = 8'h1B;
   localparam logic [7:0] CMD_DROP_MATCH = 8'h1C;
   localparam logic [7:0] CMD_DROP_DIFFERS = 8'h1D;
   localparam logic [7:0] CMD_COLLISION = 8'h08;
   localparam logic [7:0] CMD_NEXT_ROUND = 8'h09;
   localparam logic [7:0] CMD_REPEAT_NUMBER = 8'h0A;
   localparam logic [7:0] CMD_RETURN_ALL_IDLE = 8'h0B;
   localparam logic [7:0] CMD_FETCH_BLOCK = 8'h0C;
   // parameter bytes between code and crc: flag commands carry address, mask, 8 data bytes
   localparam logic [3:0] LEN_FLAG_CMD = 4'hA;
   // identification commands carry no parameter bytes
   localparam logic [3:0] LEN_IDENT_CMD = 4'h0;
   // fetch carries the 8-byte number and one address byte
   localparam logic [3:0] LEN_FETCH_CMD = 4'h9;
   // byte counter ceiling of the receive side; a longer frame is junk
   localparam logic [3:0] RX_CNT_MAX = 4'hF;
   // bytes of crc trailing every frame
   localparam logic [3:0] RX_CRC_BYTES = 4'h2;
   // slot counter values
   localparam logic [7:0] SLOT_RESET = 8'h00;
   localparam logic [7:0] SLOT_MAX = 8'hFF;
   // body bytes of every answer (number or memory block), last index
   localparam logic [2:0] TX_LAST_IDX = 3'h7;
   // crc-16, msb first, preset all ones
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_PRESET = 16'hFFFF;
   // random bit source seed, any nonzero value
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   localparam logic [15:0] LFSR_TAPS = 16'hB400;

   // tag state, gray along standby -> arbitration -> transfer
   typedef enum logic [1:0] {
      TFSA_STANDBY = 2'h0,
      TFSA_ARBITRATION = 2'h1,
      TFSA_TRANSFER = 2'h3
   } tfsa_state_t;

   // answer sequencer, gray along idle -> crc low, but the send -> load loop flips two bits
   typedef enum logic [2:0] {
      TFSA_TX_IDLE = 3'h0,
      TFSA_TX_PRE = 3'h1,
      TFSA_TX_LOAD = 3'h3,
      TFSA_TX_FILL = 3'h2,
      TFSA_TX_SEND = 3'h6,
      TFSA_TX_CRCH = 3'h7,
      TFSA_TX_CRCL = 3'h5
   } tfsa_tx_t;
endpackage

// >>> src/tfsa_crc16.sv
`timescale 1ns/1ps
// byte-wide crc-16 register, one byte per enabled cycle
module tfsa_crc16 #(
   parameter logic [15:0] POLY = tfsa_pkg::CRC_POLY,
   parameter logic [15:0] PRESET = tfsa_pkg::CRC_PRESET
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic clear,
   input wire logic en,
   input wire logic [7:0] data,
   output logic [15:0] crc
);
   logic [15:0] crc_r; // running remainder
   logic [15:0] crc_nxt;
   logic [15:0] c; // working copy

   // clear first, then fold the byte in, so clear and en together start a new frame
   always_comb
   begin
      c = clear ? PRESET : crc_r;
      if (en)
      begin
         for (int i = 7; i >= 0; i--)
         begin
            if (c[15] ^ data[i])
               c = {c[14:0], 1'b0} ^ POLY;
            else
               c = {c[14:0], 1'b0};
         end
      end
      crc_nxt = c;
   end

   // register only
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         crc_r <= PRESET;
      else if (ce)
         crc_r <= crc_nxt;
   end

   assign crc = crc_r;
endmodule

// >>> src/tfsa_mem.sv
`timescale 1ns/1ps
// tag user memory, one write port for loading, registered read port
module tfsa_mem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic ref_clk,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] store [0:(1<<AW)-1]; // contents carry no reset, like the real array
   logic [DW-1:0] rd_r; // read data register
   logic [DW-1:0] rd_nxt;

   // read next value, write-first is not needed since loads and reads never overlap
   always_comb
   begin
      rd_nxt = store[rd_addr];
   end

   // array write and read register
   always_ff @(posedge ref_clk)
   begin
      if (ce)
      begin
         rd_r <= rd_nxt;
         if (wr_en)
            store[wr_addr] <= wr_data;
      end
   end

   assign rd_data = rd_r;
endmodule

// >>> bench/tfsa_reader.sv
`timescale 1ns/1ps
// interrogator side: takes answer symbols, may stall every other cycle
module tfsa_reader (
   input wire logic ref_clk,
   input wire logic stall,
   input wire logic tx_valid,
   input wire logic tx_is_preamble,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready,
   output logic [79:0] ans_r,
   output int ans_cnt,
   output int pre_cnt
);
   initial
   begin
      tx_ready = 1'b1;
      ans_r = '0;
      ans_cnt = 0;
      pre_cnt = 0;
   end
   // shift in body and crc bytes, count preambles and whole answers
   always @(posedge ref_clk)
   begin
      if (tx_valid && tx_ready && tx_is_preamble)
         pre_cnt <= pre_cnt + 1;
      if (tx_valid && tx_ready && !tx_is_preamble)
         ans_r <= {ans_r[71:0], tx_data};
      if (tx_valid && tx_ready && tx_last)
         ans_cnt <= ans_cnt + 1;
      // ready changes only just after an edge
      tx_ready <= #1 stall ? ~tx_ready : 1'b1;
   end
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
   logic ref_clk = 1'b0, rst = 1'b1, rx_sof = 1'b0, rx_valid = 1'b0, rx_eof = 1'b0;
   logic stall = 1'b0, mem_load_en = 1'b0, tx_valid, tx_ready, tx_is_preamble, tx_last;
   logic transfer_status_bit, arbitration_active, lock_prep_valid;
   logic [7:0] rx_byte = 8'h00, tag_status_byte = 8'h5A, mem_load_addr = 8'h00;
   logic [7:0] mem_load_data = 8'h00, tx_data, slot_counter, lock_prep_addr;
   logic [63:0] unique_tag_number = 64'h0123456789ABCDEF;
   logic [79:0] ans;
   logic [7:0] p[10];
   int ans_cnt, pre_cnt, seen, lp_n = 0, err_count = 0, cmp_count = 0;
   always #2 ref_clk = ~ref_clk;
   // lock mark is a one-cycle pulse, so count it here
   always @(posedge ref_clk)
      if (lock_prep_valid === 1'b1)
         lp_n <= lp_n + 1;
   tfsa_top tfsa_top_i (.ref_clk, .rst, .ce(1'b1), .rx_sof, .rx_valid, .rx_byte, .rx_eof,
      .tag_status_byte, .unique_tag_number, .tx_valid, .tx_ready, .tx_is_preamble, .tx_data,
      .tx_last, .transfer_status_bit, .arbitration_active, .slot_counter, .lock_prep_valid,
      .lock_prep_addr, .mem_load_en, .mem_load_addr, .mem_load_data);
   tfsa_reader tfsa_reader_i (.ref_clk, .stall, .tx_valid, .tx_is_preamble, .tx_data,
      .tx_last, .tx_ready, .ans_r(ans), .ans_cnt, .pre_cnt);
   // crc-16 over one byte, msb first
   function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? tfsa_pkg::CRC_POLY : 16'h0000);
      return c;
   endfunction
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic put(input logic s, input logic v, input logic [7:0] b, input logic e);
      @(posedge ref_clk);
      #1;
      {rx_sof, rx_valid, rx_byte, rx_eof} = {s, v, b, e};
   endtask
   // one frame, then wait out an answer if one starts; bad flips a crc bit
   task automatic send(input logic [7:0] code, input int n, input logic bad);
      logic [15:0] c;
      logic busy;
      c = crc_b(tfsa_pkg::CRC_PRESET, code);
      busy = 1'b0;
      seen = ans_cnt;
      put(1'b1, 1'b0, 8'h00, 1'b0);
      put(1'b0, 1'b1, code, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         put(1'b0, 1'b1, p[i], 1'b0);
         c = crc_b(c, p[i]);
      end
      put(1'b0, 1'b1, c[15:8], 1'b0);
      put(1'b0, 1'b1, c[7:0] ^ {7'h00, bad}, 1'b0);
      put(1'b0, 1'b0, 8'h00, 1'b1);
      put(1'b0, 1'b0, 8'h00, 1'b0);
      for (int k = 0; k < 400 && ans_cnt == seen && (k < 3 || busy); k++)
      begin
         busy |= (tx_valid === 1'b1);
         @(posedge ref_clk);
         #1;
      end
   endtask
   // judge answer or silence, body and its crc, then state and slot
   task automatic judge(input logic a, input logic [63:0] b, input logic ar, input logic [7:0] s);
      logic [15:0] c;
      c = tfsa_pkg::CRC_PRESET;
      chk("answers", 64'(a), 64'(ans_cnt - seen));
      chk("preambles", 64'(ans_cnt), 64'(pre_cnt));
      if (a)
      begin
         for (int i = 7; i >= 0; i--)
            c = crc_b(c, b[8*i +: 8]);
         chk("body", b, ans[79:16]);
         chk("crc", 64'(c), 64'(ans[15:0]));
      end
      chk("arb", 64'(ar), 64'(arbitration_active));
      chk("slot", 64'(s), 64'(slot_counter));
   endtask
   task automatic fj(input logic [7:0] code, input logic [7:0] d, input logic [7:0] m,
         input logic bad, input logic a, input logic ar);
      p = '{8'h00, m, d, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      send(code, 10, bad);
      judge(a, unique_tag_number, ar, 8'h00);
   endtask
   task automatic t_flags();
      fj(tfsa_pkg::CMD_PICK_DIFFERS, 8'h5A, 8'hFF, 1'b0, 1'b0, 1'b0);
      stall = 1'b1;
      fj(tfsa_pkg::CMD_PICK_MATCH, 8'h5A, 8'hFF, 1'b0, 1'b1, 1'b1);
      stall = 1'b0;
      fj(tfsa_pkg::CMD_DROP_MATCH, 8'h5A, 8'hFF, 1'b1, 1'b0, 1'b1);
      fj(tfsa_pkg::CMD_DROP_DIFFERS, 8'h5A, 8'hFF, 1'b0, 1'b1, 1'b1);
      fj(tfsa_pkg::CMD_DROP_MATCH, 8'h5A, 8'hFF, 1'b0, 1'b0, 1'b0);
      fj(tfsa_pkg::CMD_DROP_DIFFERS, 8'h33, 8'hFF, 1'b0, 1'b0, 1'b0);
      fj(tfsa_pkg::CMD_PICK_MATCH, 8'h00, 8'h00, 1'b0, 1'b1, 1'b1);
      fj(tfsa_pkg::CMD_PICK_DIFFERS, 8'h5A, 8'hFF, 1'b0, 1'b1, 1'b1);
      fj(tfsa_pkg::CMD_DROP_DIFFERS, 8'h33, 8'hFF, 1'b0, 1'b0, 1'b0);
      fj(tfsa_pkg::CMD_PICK_DIFFERS, 8'h33, 8'hFF, 1'b0, 1'b1, 1'b1);
   endtask
   // the random bit decides when the counter first leaves zero
   task automatic t_slots();
      for (int i = 0; i < 40 && slot_counter === 8'h00; i++)
      begin
         send(tfsa_pkg::CMD_COLLISION, 0, 1'b0);
         judge(slot_counter === 8'h00, unique_tag_number, 1'b1,
            8'(slot_counter !== 8'h00));
      end
      chk("slot", 64'h1, 64'(slot_counter));
      send(tfsa_pkg::CMD_COLLISION, 0, 1'b0);
      judge(1'b0, 64'h0, 1'b1, 8'h02);
      send(tfsa_pkg::CMD_REPEAT_NUMBER, 0, 1'b0);
      judge(1'b0, 64'h0, 1'b1, 8'h02);
      send(tfsa_pkg::CMD_NEXT_ROUND, 0, 1'b0);
      judge(1'b0, 64'h0, 1'b1, 8'h01);
      send(tfsa_pkg::CMD_NEXT_ROUND, 0, 1'b0);
      judge(1'b1, unique_tag_number, 1'b1, 8'h00);
      send(tfsa_pkg::CMD_REPEAT_NUMBER, 0, 1'b0);
      judge(1'b1, unique_tag_number, 1'b1, 8'h00);
      send(tfsa_pkg::CMD_NEXT_ROUND, 0, 1'b0);
      judge(1'b1, unique_tag_number, 1'b1, 8'h00);
      for (int i = 0; i < 400 && slot_counter !== 8'hFF; i++)
         send(tfsa_pkg::CMD_COLLISION, 0, 1'b0);
      send(tfsa_pkg::CMD_COLLISION, 0, 1'b0);
      judge(1'b0, 64'h0, 1'b1, 8'hFF);
      send(tfsa_pkg::CMD_RETURN_ALL_IDLE, 0, 1'b0);
      judge(1'b0, 64'h0, 1'b0, 8'hFF);
   endtask
   // memory block wraps past FF; a wrong number must stay silent
   task automatic t_fetch();
      for (int i = 0; i < 9; i++)
      begin
         @(posedge ref_clk);
         #1;
         {mem_load_en, mem_load_addr, mem_load_data} = {i < 8, 8'(8'hFE + i), 8'(8'h11 * i + 1)};
         p[i] = (i < 8) ? unique_tag_number[63-8*i -: 8] : 8'hFE;
      end
      p[7] ^= 8'h01;
      send(tfsa_pkg::CMD_FETCH_BLOCK, 9, 1'b0);
      judge(1'b0, 64'h0, 1'b0, 8'hFF);
      p[7] ^= 8'h01;
      send(tfsa_pkg::CMD_FETCH_BLOCK, 9, 1'b0);
      judge(1'b1, 64'h0112233445566778, 1'b0, 8'hFF);
      chk("xfer", 64'h1, 64'(transfer_status_bit));
      chk("marks", 64'h1, 64'(lp_n));
      chk("mark addr", 64'hFE, 64'(lock_prep_addr));
      send(tfsa_pkg::CMD_RETURN_ALL_IDLE, 0, 1'b0);
      judge(1'b0, 64'h0, 1'b0, 8'hFF);
      chk("xfer", 64'h0, 64'(transfer_status_bit));
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      err_count++;
      end_sim();
   end
   initial
   begin
      repeat (10) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      chk("slot", 64'h0, 64'(slot_counter));
      t_flags();
      t_slots();
      t_fetch();
      end_sim();
   end
endmodule
